// ===== rtl/dcc_pkg.sv
package dcc_pkg;

    // =====================================================================
    // register map
    // =====================================================================
    localparam int unsigned  REG_W                = 8;
    localparam int unsigned  NUM_REGS             = 4;
    localparam logic [7:0]   OFF_PLL_CONTROL_AND_LOCK        = 8'h04;
    localparam logic [7:0]   OFF_PAGE_INCREMENT_CONTROL      = 8'h06;
    localparam logic [7:0]   OFF_DEEMPHASIS_AND_OUTPUT_SELECT = 8'h07;
    localparam logic [7:0]   OFF_PIN_DIRECTION_AND_MUTE_GATE = 8'h08;

    // register slots in the bank
    localparam int unsigned  IDX_PLL              = 0;
    localparam int unsigned  IDX_PAGE             = 1;
    localparam int unsigned  IDX_DSEL             = 2;
    localparam int unsigned  IDX_PIN              = 3;

    // =====================================================================
    // reset values and writable masks
    // =====================================================================
    localparam logic [7:0]   RST_PLL              = 8'h01;
    localparam logic [7:0]   RST_PAGE             = 8'h00;
    localparam logic [7:0]   RST_DSEL             = 8'h01;
    localparam logic [7:0]   RST_PIN              = 8'h00;
    localparam logic [7:0]   WMASK_PLL            = 8'hEF;
    localparam logic [7:0]   WMASK_ALL            = 8'hFF;
    localparam logic [7:0]   RDATA_UNMAPPED       = 8'h00;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int unsigned  BIT_PLL_ON           = 0;
    localparam int unsigned  BIT_PLL_LOCK_FLAG    = 4;
    localparam int unsigned  BIT_PAGE_WRAP        = 3;
    localparam int unsigned  BIT_DEEMPH_ON        = 4;
    localparam int unsigned  BIT_SOUT_SRC_SEL     = 0;
    localparam int unsigned  BIT_SOUT_PIN_DIR     = 5;
    localparam int unsigned  BIT_MUTE_GATE        = 4;

    // lock flag encoding
    localparam logic         LOCK_FLAG_LOCKED     = 1'b0;
    localparam logic         LOCK_FLAG_UNLOCKED   = 1'b1;

    // =====================================================================
    // paged access
    // =====================================================================
    localparam int unsigned  PADDR_W              = 7;
    localparam logic [6:0]   PAGE_LAST_ADDR       = 7'h7F;
    localparam logic [6:0]   NEXT_PAGE_FIRST_ADDR = 7'h08;
    localparam logic [6:0]   SAME_PAGE_FIRST_ADDR = 7'h00;
    localparam logic [7:0]   BOOK_ZERO            = 8'h00;
    localparam logic [7:0]   PAGE_ONE             = 8'h01;

    // de-emphasis default sample rate, coefficients live in external RAM
    localparam int unsigned  DEEMPH_DEFAULT_FS_HZ = 44100;

    typedef struct packed {
        logic       pll_on;
        logic       page_wrap_control;
        logic       deemph_on;
        logic       serial_out_source_select;
        logic       serial_out_pin_direction;
        logic       power_stage_mute_gate;
    } dcc_cfg_t;

    typedef struct packed {
        logic [7:0] book;
        logic [7:0] page;
        logic [6:0] addr;
    } dcc_paddr_t;

endpackage

// ===== rtl/dcc_sync3.sv
`timescale 1ns/1ns
module dcc_sync3
    import dcc_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level
);

    // =====================================================================
    // three-stage capture, change accepted once stages two and three agree
    // =====================================================================
    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;

    always_comb begin
        s1_d  = i_async;
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;

    // =====================================================================
    // checks
    // =====================================================================
    a_sync_agree: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $changed(lvl_q) |-> $past(s2_q) == $past(s3_q))
        else $error("sync level changed without agreeing stages");

endmodule

// ===== rtl/dcc_page_step.sv
`timescale 1ns/1ns
module dcc_page_step
    import dcc_pkg::*;
(
    input  dcc_paddr_t i_cur,
    input  wire logic  i_wrap_same_page,
    output dcc_paddr_t o_next
);

    // =====================================================================
    // next location of an auto-incrementing access
    // =====================================================================
    always_comb begin
        o_next = i_cur;
        if (i_cur.addr != PAGE_LAST_ADDR) begin
            o_next.addr = i_cur.addr + 7'h01;
        end else if (i_cur.book != BOOK_ZERO && !i_wrap_same_page) begin
            o_next.page = i_cur.page + PAGE_ONE;
            o_next.addr = NEXT_PAGE_FIRST_ADDR;
        end else begin
            o_next.addr = SAME_PAGE_FIRST_ADDR;
        end
    end

endmodule

// ===== rtl/dcc_top.sv
`timescale 1ns/1ns
// Operation
// - lock flag bit 4 reads 0 locked
// - PLL disabled forces lock flag unlocked
// - PLL enable bit 0 resets to 1
// - PLL off selects external master clock
// - nonzero book wrap0 continues next page 8
// - wrap bit 3 set returns to same page 0
// - bit 4 enables de-emphasis, reset 0
// - de-emphasis defaults 44.1 kHz, RAM replaceable
// - bit 0 selects pre or post data
// - bit 5 sets serial output pin direction
// - bit 4 gates mute to power stage
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // control port
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_rvalid,
    // paged auto-increment
    input  wire logic       i_acc_step,
    input  wire logic       i_acc_load,
    input  dcc_paddr_t      i_acc_start,
    output dcc_paddr_t      o_acc_cur,
    // clocking
    input  wire logic       i_pll_locked,
    output logic            o_pll_on,
    output logic            o_mclk_sel_pll,
    // processing
    output logic            o_deemph_on,
    input  wire logic       i_pre_data,
    input  wire logic       i_post_data,
    // serial audio output pin
    output logic            o_serial_audio_output_o,
    output logic            o_serial_audio_output_oe_n,
    input  wire logic       i_serial_audio_output_i,
    output logic            o_serial_audio_output_in,
    // mute path
    input  wire logic       i_dac_mute,
    output logic            o_pstage_mute
);

    // =====================================================================
    // decode helpers
    // =====================================================================
    function automatic logic [NUM_REGS-1:0] decode(input logic [7:0] addr);
        decode = '0;
        case (addr)
            OFF_PLL_CONTROL_AND_LOCK:         decode[IDX_PLL]  = 1'b1;
            OFF_PAGE_INCREMENT_CONTROL:       decode[IDX_PAGE] = 1'b1;
            OFF_DEEMPHASIS_AND_OUTPUT_SELECT: decode[IDX_DSEL] = 1'b1;
            OFF_PIN_DIRECTION_AND_MUTE_GATE:  decode[IDX_PIN]  = 1'b1;
            default:                          decode           = '0;
        endcase
    endfunction

    localparam logic [7:0] RST_TAB [NUM_REGS] = '{RST_PLL, RST_PAGE, RST_DSEL, RST_PIN};
    localparam logic [7:0] WM_TAB  [NUM_REGS] = '{WMASK_PLL, WMASK_ALL, WMASK_ALL, WMASK_ALL};

    logic [NUM_REGS-1:0] wr_hit;
    logic [NUM_REGS-1:0] rd_hit;
    logic [7:0]          regs_q [NUM_REGS];
    logic [7:0]          regs_d [NUM_REGS];

    assign wr_hit = i_reg_wr ? decode(i_reg_addr) : '0;
    assign rd_hit = decode(i_reg_addr);

    // =====================================================================
    // register bank
    // =====================================================================
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_comb begin
                regs_d[g] = regs_q[g];
                if (wr_hit[g]) begin
                    regs_d[g] = (i_reg_wdata & WM_TAB[g]) | (regs_q[g] & ~WM_TAB[g]);
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    regs_q[g] <= RST_TAB[g];
                end else begin
                    regs_q[g] <= regs_d[g];
                end
            end
        end
    endgenerate

    dcc_cfg_t cfg;

    always_comb begin
        cfg.pll_on                   = regs_q[IDX_PLL][BIT_PLL_ON];
        cfg.page_wrap_control        = regs_q[IDX_PAGE][BIT_PAGE_WRAP];
        cfg.deemph_on                = regs_q[IDX_DSEL][BIT_DEEMPH_ON];
        cfg.serial_out_source_select = regs_q[IDX_DSEL][BIT_SOUT_SRC_SEL];
        cfg.serial_out_pin_direction = regs_q[IDX_PIN][BIT_SOUT_PIN_DIR];
        cfg.power_stage_mute_gate    = regs_q[IDX_PIN][BIT_MUTE_GATE];
    end

    // =====================================================================
    // pll lock status
    // =====================================================================
    logic lock_sync;
    logic pll_lock_flag;

    dcc_sync3 #(
        .RST_VAL (1'b0)
    ) u_lock_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_pll_locked),
        .o_level   (lock_sync)
    );

    // not locked whenever the pll is off
    assign pll_lock_flag = (cfg.pll_on && lock_sync) ? LOCK_FLAG_LOCKED
                                                     : LOCK_FLAG_UNLOCKED;

    // =====================================================================
    // read path
    // =====================================================================
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = i_reg_rd;
        if (i_reg_rd) begin
            rdata_d = RDATA_UNMAPPED;
            for (int i = 0; i < NUM_REGS; i++) begin
                if (rd_hit[i]) begin
                    rdata_d = regs_q[i];
                end
            end
            if (rd_hit[IDX_PLL]) begin
                rdata_d[BIT_PLL_LOCK_FLAG] = pll_lock_flag;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign o_reg_rdata  = rdata_q;
    assign o_reg_rvalid = rvalid_q;

    // =====================================================================
    // paged auto-increment pointer
    // =====================================================================
    dcc_paddr_t acc_q, acc_d, acc_next;

    dcc_page_step u_page_step (
        .i_cur            (acc_q),
        .i_wrap_same_page (cfg.page_wrap_control),
        .o_next           (acc_next)
    );

    always_comb begin
        acc_d = acc_q;
        if (i_acc_load) begin
            acc_d = i_acc_start;
        end else if (i_acc_step) begin
            acc_d = acc_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign o_acc_cur = acc_q;

    // =====================================================================
    // datapath controls
    // =====================================================================
    logic sout_q, sout_d;
    logic mute_q, mute_d;
    logic sin_sync;

    always_comb begin
        sout_d = cfg.serial_out_source_select ? i_pre_data : i_post_data;
        mute_d = cfg.power_stage_mute_gate & i_dac_mute;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sout_q <= 1'b0;
            mute_q <= 1'b0;
        end else begin
            sout_q <= sout_d;
            mute_q <= mute_d;
        end
    end

    dcc_sync3 #(
        .RST_VAL (1'b0)
    ) u_sin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_serial_audio_output_i),
        .o_level   (sin_sync)
    );

    assign o_pll_on                   = cfg.pll_on;
    assign o_mclk_sel_pll             = cfg.pll_on;
    // coefficient RAM holds 44.1 kHz defaults, software may overwrite them
    assign o_deemph_on                = cfg.deemph_on;
    assign o_serial_audio_output_o    = sout_q;
    assign o_serial_audio_output_oe_n = ~cfg.serial_out_pin_direction;
    assign o_serial_audio_output_in   = sin_sync;
    assign o_pstage_mute              = mute_q;

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_lock_flag_read: assert property (
        i_reg_rd && i_reg_addr == OFF_PLL_CONTROL_AND_LOCK && regs_q[IDX_PLL][BIT_PLL_ON]
        && lock_sync |=> o_reg_rvalid && o_reg_rdata[BIT_PLL_LOCK_FLAG] == LOCK_FLAG_LOCKED)
        else $error("locked pll not read as locked");

    a_lock_when_off: assert property (
        i_reg_rd && i_reg_addr == OFF_PLL_CONTROL_AND_LOCK && !o_pll_on
        |=> o_reg_rdata[BIT_PLL_LOCK_FLAG] == LOCK_FLAG_UNLOCKED)
        else $error("disabled pll read as locked");

    a_pll_write: assert property (
        i_reg_wr && i_reg_addr == OFF_PLL_CONTROL_AND_LOCK
        |=> o_pll_on == $past(i_reg_wdata[BIT_PLL_ON]))
        else $error("pll enable not taken from write");

    a_mclk_fallback: assert property (
        i_reg_wr && i_reg_addr == OFF_PLL_CONTROL_AND_LOCK
        |=> o_mclk_sel_pll == $past(i_reg_wdata[BIT_PLL_ON]))
        else $error("master clock source not following pll enable write");

    a_page_next: assert property (
        i_acc_step && !i_acc_load && o_acc_cur.addr == PAGE_LAST_ADDR
        && o_acc_cur.book != BOOK_ZERO && !cfg.page_wrap_control
        |=> o_acc_cur.addr == NEXT_PAGE_FIRST_ADDR
            && o_acc_cur.page == $past(o_acc_cur.page) + PAGE_ONE)
        else $error("end of page did not move to next page");

    a_page_same: assert property (
        i_acc_step && !i_acc_load && o_acc_cur.addr == PAGE_LAST_ADDR && cfg.page_wrap_control
        |=> o_acc_cur.addr == SAME_PAGE_FIRST_ADDR && $stable(o_acc_cur.page))
        else $error("wrap did not stay on page");

    a_deemph_write: assert property (
        i_reg_wr && i_reg_addr == OFF_DEEMPHASIS_AND_OUTPUT_SELECT
        |=> o_deemph_on == $past(i_reg_wdata[BIT_DEEMPH_ON]))
        else $error("de-emphasis enable not taken");

    a_sout_select: assert property (
        ##1 o_serial_audio_output_o == ($past(cfg.serial_out_source_select)
            ? $past(i_pre_data) : $past(i_post_data)))
        else $error("serial output source wrong");

    a_pin_direction: assert property (
        o_serial_audio_output_oe_n == !regs_q[IDX_PIN][BIT_SOUT_PIN_DIR])
        else $error("serial output pin direction wrong");

    a_mute_gate: assert property (
        o_pstage_mute == ($past(cfg.power_stage_mute_gate) && $past(i_dac_mute)))
        else $error("power stage mute not gated request");

    c_pll_off: cover property (o_pll_on ##1 !o_pll_on);
    c_next_page: cover property (i_acc_step && o_acc_cur.addr == PAGE_LAST_ADDR
                                 && o_acc_cur.book != BOOK_ZERO);
    c_pin_output: cover property (!o_serial_audio_output_oe_n);
    c_mute_pass: cover property (o_pstage_mute);

endmodule

// ===== testbench/dcc_top_tb.sv
`timescale 1ns/1ns
module dcc_top_tb
    import dcc_pkg::*;
;
    // =====================================================================
    // stimulus and observed signals
    // =====================================================================
    logic       clk_sys;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       acc_step;
    logic       acc_load;
    dcc_paddr_t acc_start;
    dcc_paddr_t acc_cur;
    logic       pll_locked;
    logic       pll_on;
    logic       mclk_sel_pll;
    logic       deemph_on;
    logic       pre_data;
    logic       post_data;
    logic       sout_o;
    logic       sout_oe_n;
    logic       sout_i;
    logic       sout_in;
    logic       dac_mute;
    logic       pstage_mute;
    int         err_total;
    int         check_count;

    dcc_top dut (
        .i_clk_sys                  (clk_sys),
        .i_rst                      (rst),
        .i_reg_wr                   (reg_wr),
        .i_reg_rd                   (reg_rd),
        .i_reg_addr                 (reg_addr),
        .i_reg_wdata                (reg_wdata),
        .o_reg_rdata                (reg_rdata),
        .o_reg_rvalid               (reg_rvalid),
        .i_acc_step                 (acc_step),
        .i_acc_load                 (acc_load),
        .i_acc_start                (acc_start),
        .o_acc_cur                  (acc_cur),
        .i_pll_locked               (pll_locked),
        .o_pll_on                   (pll_on),
        .o_mclk_sel_pll             (mclk_sel_pll),
        .o_deemph_on                (deemph_on),
        .i_pre_data                 (pre_data),
        .i_post_data                (post_data),
        .o_serial_audio_output_o    (sout_o),
        .o_serial_audio_output_oe_n (sout_oe_n),
        .i_serial_audio_output_i    (sout_i),
        .o_serial_audio_output_in   (sout_in),
        .i_dac_mute                 (dac_mute),
        .o_pstage_mute              (pstage_mute)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // =====================================================================
    // compare, report and bus tasks
    // =====================================================================
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic chkp(input string name, input dcc_paddr_t exp, input dcc_paddr_t got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // read strobe, then answer registered on the taking edge and checked at the next negedge
    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk1("rvalid", 1'b1, reg_rvalid);
        chk8("rdata", exp, reg_rdata);
        @(negedge clk_sys);
        chk1("rvalid_drop", 1'b0, reg_rvalid);
    endtask

    task automatic acc_pulse(input logic ld, input logic st);
        @(negedge clk_sys);
        acc_load = ld;
        acc_step = st;
        @(negedge clk_sys);
        acc_load = 1'b0;
        acc_step = 1'b0;
    endtask

    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic t_reset_values();
        reg_check(8'h04, 8'h11);
        reg_check(8'h06, 8'h00);
        reg_check(8'h07, 8'h01);
        reg_check(8'h08, 8'h00);
        reg_check(8'h05, 8'h00);
        chk1("pll_on", 1'b1, pll_on);
        chk1("mclk_sel", 1'b1, mclk_sel_pll);
        chk1("deemph", 1'b0, deemph_on);
        chk1("oe_n", 1'b1, sout_oe_n);
    endtask

    task automatic t_pll_lock();
        pll_locked = 1'b1;
        repeat (6) @(negedge clk_sys);
        reg_check(8'h04, 8'h01);
        reg_write(8'h04, 8'h00);
        chk1("pll_on", 1'b0, pll_on);
        chk1("mclk_sel", 1'b0, mclk_sel_pll);
        reg_check(8'h04, 8'h10);
        reg_write(8'h04, 8'hFF);
        reg_check(8'h04, 8'hEF);
        chk1("mclk_sel", 1'b1, mclk_sel_pll);
        pll_locked = 1'b0;
        repeat (6) @(negedge clk_sys);
        reg_check(8'h04, 8'hFF);
        reg_write(8'h04, 8'h01);
    endtask

    task automatic t_page_wrap();
        acc_start = '{book: 8'h01, page: 8'h02, addr: 7'h7F};
        acc_pulse(1'b1, 1'b0);
        acc_pulse(1'b0, 1'b1);
        chkp("ptr", '{book: 8'h01, page: 8'h03, addr: 7'h08}, acc_cur);
        acc_pulse(1'b0, 1'b1);
        chkp("ptr", '{book: 8'h01, page: 8'h03, addr: 7'h09}, acc_cur);
        reg_write(8'h06, 8'h08);
        reg_check(8'h06, 8'h08);
        acc_pulse(1'b1, 1'b0);
        acc_pulse(1'b0, 1'b1);
        chkp("ptr", '{book: 8'h01, page: 8'h02, addr: 7'h00}, acc_cur);
        reg_write(8'h06, 8'h00);
        acc_start = '{book: 8'h00, page: 8'h05, addr: 7'h7F};
        acc_pulse(1'b1, 1'b1);
        chkp("ptr_load", '{book: 8'h00, page: 8'h05, addr: 7'h7F}, acc_cur);
        acc_pulse(1'b0, 1'b1);
        chkp("ptr_book0", '{book: 8'h00, page: 8'h05, addr: 7'h00}, acc_cur);
    endtask

    task automatic t_deemph_select();
        pre_data  = 1'b1;
        post_data = 1'b0;
        @(negedge clk_sys);
        chk1("sout", 1'b1, sout_o);
        reg_write(8'h07, 8'h10);
        chk1("deemph", 1'b1, deemph_on);
        @(negedge clk_sys);
        chk1("sout", 1'b0, sout_o);
        post_data = 1'b1;
        pre_data  = 1'b0;
        @(negedge clk_sys);
        chk1("sout", 1'b1, sout_o);
        reg_check(8'h07, 8'h10);
    endtask

    task automatic t_pin_mute();
        dac_mute = 1'b1;
        @(negedge clk_sys);
        chk1("pstage_mute", 1'b0, pstage_mute);
        reg_write(8'h08, 8'h30);
        chk1("oe_n", 1'b0, sout_oe_n);
        @(negedge clk_sys);
        chk1("pstage_mute", 1'b1, pstage_mute);
        reg_write(8'h08, 8'h20);
        @(negedge clk_sys);
        chk1("pstage_mute", 1'b0, pstage_mute);
        reg_write(8'h08, 8'h00);
        chk1("oe_n", 1'b1, sout_oe_n);
        sout_i = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk1("sout_in", 1'b1, sout_in);
    endtask

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        err_total   = 0;
        check_count = 0;
        rst         = 1'b1;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        acc_step    = 1'b0;
        acc_load    = 1'b0;
        acc_start   = '0;
        pll_locked  = 1'b0;
        pre_data    = 1'b0;
        post_data   = 1'b0;
        sout_i      = 1'b0;
        dac_mute    = 1'b0;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        t_reset_values();
        t_pll_lock();
        t_page_wrap();
        t_deemph_select();
        t_pin_mute();
        end_sim();
    end

    // hang guard
    initial begin
        #100000;
        err_total++;
        end_sim();
    end

endmodule
